// file: pkg/ppf_pkg.sv
package ppf_pkg;

  localparam int ADDR_W = 4;

  // Register offsets
  localparam logic [3:0] ADDR_BIDIR_DATA = 4'h0;
  localparam logic [3:0] ADDR_BIDIR_DIR = 4'h1;
  localparam logic [3:0] ADDR_PORT_MODE = 4'h2;
  localparam logic [3:0] ADDR_PORT_CTRL = 4'h3;
  localparam logic [3:0] ADDR_FIXED_DATA = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EDGE = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;

  // Field positions of input_port_mode_reg
  localparam int MODE_OPEN_DRAIN = 0;
  localparam int MODE_ANALOG = 1;
  localparam int MODE_TIMER_OUT = 2;

  // Field positions of port_control_reg
  localparam int PCTL_COMP_OUT = 0;
  localparam int PCTL_EMI_BIDIR = 1;
  localparam int PCTL_EMI_FIXED = 2;
  localparam int PCTL_EMI_OSC = 3;

  // Edge select field of interrupt_request_one
  localparam int EDGE_LSB = 6;
  localparam int EDGE_MSB = 7;

  // Interrupt status and mask bit positions
  localparam int IRQ_LINE2 = 0;
  localparam int IRQ_LINE3 = 1;
  localparam int IRQ_LINE1 = 2;

  // Fixed port field positions in the data register
  localparam int FIX_IN_LSB = 1;
  localparam int FIX_OUT_LSB = 4;

  // Reset values
  localparam logic [7:0] BIDIR_DATA_RST = 8'h00;
  localparam logic [7:0] BIDIR_DIR_RST = 8'hff;
  localparam logic [2:0] PORT_MODE_RST = 3'h0;
  localparam logic [3:0] PORT_CTRL_RST = 4'h0;
  localparam logic [2:0] FIXED_DATA_RST = 3'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef enum logic [1:0] {
    EDGE_FALL,
    EDGE_RISE,
    EDGE_BOTH,
    EDGE_BOTH_ALT
  } ppf_edge_e;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } ppf_bus_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } ppf_bidir_drv_s;

  typedef struct packed {
    logic [2:0] out;
    logic [2:0] oe;
  } ppf_fixed_drv_s;

endpackage : ppf_pkg

// file: design/ppf_edge_det.sv
`timescale 1ns/1ns
`default_nettype none

module ppf_edge_det
  import ppf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic level_i,
  input wire logic rise_en_i,
  input wire logic fall_en_i,
  output logic event_o
);

  logic prev_reg;

  // Previous level of the source
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= level_i;
    end
  end

  // Pulse on a selected edge
  always_comb begin
    event_o = (rise_en_i & level_i & ~prev_reg) |
              (fall_en_i & ~level_i & prev_reg);
  end

endmodule : ppf_edge_det

`default_nettype wire

// file: design/ppf_keeper.sv
`timescale 1ns/1ns
`default_nettype none

module ppf_keeper
  import ppf_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] pin_in_i,
  input wire logic [W-1:0] drive_oe_i,
  output logic [W-1:0] keep_val_o,
  output logic [W-1:0] keep_en_o
);

  logic [W-1:0] level_reg;

  // Last level seen on each line
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      level_reg <= '0;
    end else begin
      level_reg <= pin_in_i;
    end
  end

  // Keeper holds a line whenever this end does not drive it
  always_comb begin
    keep_val_o = level_reg;
    keep_en_o = ~drive_oe_i;
  end

endmodule : ppf_keeper

`default_nettype wire

// file: design/ppf_port_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

module ppf_port_ctrl
  import ppf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire ppf_bus_req_s bus_req_i,
  output logic [7:0] bus_rdata_o,
  input wire logic [7:0] bidir_in_i,
  output ppf_bidir_drv_s bidir_drv_o,
  output logic [7:0] keep_val_o,
  output logic [7:0] keep_en_o,
  input wire logic [2:0] fixed_in_i,
  input wire logic [1:0] fixed_io_in_i,
  output ppf_fixed_drv_s fixed_drv_o,
  input wire logic [1:0] comp_result_i,
  output logic comp_analog_o,
  output logic osc_low_emi_o,
  output logic bidir_low_emi_o,
  output logic fixed_low_emi_o,
  input wire logic spi_en_i,
  input wire logic spi_slave_i,
  input wire logic spi_dout_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_sck_oe_i,
  output logic spi_din_o,
  output logic spi_sck_in_o,
  output logic spi_ss_o,
  input wire logic timer_out_i,
  output logic timer_ext_in_o,
  output logic irq_o
);

  logic [7:0] data_reg;
  logic [7:0] dir_reg;
  logic [2:0] mode_reg;
  logic [3:0] pctl_reg;
  logic [2:0] fixed_reg;
  ppf_edge_e edge_reg;
  logic [2:0] stat_reg;
  logic [2:0] mask_reg;
  logic [7:0] rdata_reg;
  ppf_bidir_drv_s bidir_reg;
  ppf_fixed_drv_s fixed_drv_reg;
  logic spi_din_reg;
  logic spi_sck_in_reg;
  logic spi_ss_reg;
  logic tin_reg;

  logic [7:0] rdata_next;
  ppf_bidir_drv_s bidir_next;
  ppf_fixed_drv_s fixed_next;
  logic [2:0] fix_rd;
  logic [2:0] evt;
  logic analog;
  logic src_line1;
  logic src_line2;
  logic rise_en;
  logic fall_en;
  logic wr_hit;

  assign analog = mode_reg[MODE_ANALOG];
  assign wr_hit = bus_req_i.we;

  // Register writes
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_reg <= BIDIR_DATA_RST;
      dir_reg <= BIDIR_DIR_RST;
      mode_reg <= PORT_MODE_RST;
      pctl_reg <= PORT_CTRL_RST;
      fixed_reg <= FIXED_DATA_RST;
      edge_reg <= EDGE_FALL;
      mask_reg <= IRQ_RST;
    end else if (wr_hit) begin
      unique case (bus_req_i.addr)
        ADDR_BIDIR_DATA: begin
          data_reg <= bus_req_i.wdata;
        end
        ADDR_BIDIR_DIR: begin
          dir_reg <= bus_req_i.wdata;
        end
        ADDR_PORT_MODE: begin
          mode_reg <= bus_req_i.wdata[2:0];
        end
        ADDR_PORT_CTRL: begin
          pctl_reg <= bus_req_i.wdata[3:0];
        end
        ADDR_FIXED_DATA: begin
          fixed_reg <= bus_req_i.wdata[FIX_OUT_LSB +: 3];
        end
        ADDR_IRQ_EDGE: begin
          edge_reg <= ppf_edge_e'(bus_req_i.wdata[EDGE_MSB:EDGE_LSB]);
        end
        ADDR_IRQ_MASK: begin
          mask_reg <= bus_req_i.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Line 1 and line 2 sources: comparator results in analog mode, pins otherwise
  assign src_line1 = analog ? comp_result_i[0] : fixed_in_i[0];
  assign src_line2 = analog ? comp_result_i[1] : fixed_in_i[1];

  always_comb begin
    rise_en = (edge_reg != EDGE_FALL);
    fall_en = (edge_reg != EDGE_RISE);
  end

  ppf_edge_det u_edge_line1 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .level_i(src_line1),
    .rise_en_i(rise_en),
    .fall_en_i(fall_en),
    .event_o(evt[IRQ_LINE1])
  );

  ppf_edge_det u_edge_line2 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .level_i(src_line2),
    .rise_en_i(rise_en),
    .fall_en_i(fall_en),
    .event_o(evt[IRQ_LINE2])
  );

  ppf_edge_det u_edge_line3 (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .level_i(fixed_in_i[2]),
    .rise_en_i(1'b0),
    .fall_en_i(~analog),
    .event_o(evt[IRQ_LINE3])
  );

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat_reg <= IRQ_RST;
    end else begin
      if (wr_hit && bus_req_i.addr == ADDR_IRQ_STAT) begin
        stat_reg <= (stat_reg & ~bus_req_i.wdata[2:0]) | evt;
      end else begin
        stat_reg <= stat_reg | evt;
      end
    end
  end

  assign irq_o = |(stat_reg & mask_reg);

  // Fixed input read view
  always_comb begin
    if (analog) begin
      fix_rd = {1'b0, comp_result_i};
    end else begin
      fix_rd = fixed_in_i;
    end
  end

  // Read data
  always_comb begin
    rdata_next = 8'h00;
    if (bus_req_i.re) begin
      unique case (bus_req_i.addr)
        ADDR_BIDIR_DATA: begin
          rdata_next = bidir_in_i;
        end
        ADDR_BIDIR_DIR: begin
          rdata_next = dir_reg;
        end
        ADDR_PORT_MODE: begin
          rdata_next = {5'h00, mode_reg};
        end
        ADDR_PORT_CTRL: begin
          rdata_next = {4'h0, pctl_reg};
        end
        ADDR_FIXED_DATA: begin
          rdata_next[FIX_IN_LSB +: 3] = fix_rd;
          rdata_next[FIX_OUT_LSB +: 3] = fixed_reg;
        end
        ADDR_IRQ_EDGE: begin
          rdata_next[EDGE_MSB:EDGE_LSB] = edge_reg;
        end
        ADDR_IRQ_STAT: begin
          rdata_next = {5'h00, stat_reg};
        end
        ADDR_IRQ_MASK: begin
          rdata_next = {5'h00, mask_reg};
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus_rdata_o = rdata_reg;

  // Bidirectional port drive
  always_comb begin
    logic [7:0] val;
    logic [7:0] is_out;
    val = data_reg;
    is_out = ~dir_reg;
    if (spi_en_i) begin
      is_out[0] = 1'b0;
      is_out[7] = 1'b1;
      val[7] = spi_dout_i;
    end
    if (mode_reg[MODE_OPEN_DRAIN]) begin
      bidir_next.out = 8'h00;
      bidir_next.oe = is_out & ~val;
    end else begin
      bidir_next.out = val & is_out;
      bidir_next.oe = is_out;
    end
  end

  // Fixed output drive, always push-pull unless serial takes a line
  always_comb begin
    fixed_next.out = fixed_reg;
    fixed_next.oe = 3'b111;
    if (pctl_reg[PCTL_COMP_OUT]) begin
      fixed_next.out[1:0] = comp_result_i;
    end
    if (spi_en_i) begin
      fixed_next.out[0] = spi_sck_out_i;
      fixed_next.oe[0] = spi_sck_oe_i;
      if (spi_slave_i) begin
        fixed_next.out[1] = 1'b0;
        fixed_next.oe[1] = 1'b0;
      end
    end
    if (mode_reg[MODE_TIMER_OUT]) begin
      fixed_next.out[2] = timer_out_i;
    end
  end

  // Pin and peripheral side flops
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bidir_reg <= '0;
      fixed_drv_reg <= '0;
    end else begin
      bidir_reg <= bidir_next;
      fixed_drv_reg <= fixed_next;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spi_din_reg <= 1'b0;
      spi_sck_in_reg <= 1'b0;
      spi_ss_reg <= 1'b1;
      tin_reg <= 1'b0;
    end else begin
      spi_din_reg <= spi_en_i & bidir_in_i[0];
      spi_sck_in_reg <= spi_en_i & fixed_io_in_i[0];
      spi_ss_reg <= ~(spi_en_i & spi_slave_i) | fixed_io_in_i[1];
      tin_reg <= src_line1;
    end
  end

  assign bidir_drv_o = bidir_reg;
  assign fixed_drv_o = fixed_drv_reg;
  assign spi_din_o = spi_din_reg;
  assign spi_sck_in_o = spi_sck_in_reg;
  assign spi_ss_o = spi_ss_reg;
  assign timer_ext_in_o = tin_reg;
  assign comp_analog_o = analog;

  // Separate low-emission selections
  assign osc_low_emi_o = pctl_reg[PCTL_EMI_OSC];
  assign bidir_low_emi_o = pctl_reg[PCTL_EMI_BIDIR];
  assign fixed_low_emi_o = pctl_reg[PCTL_EMI_FIXED];

  // Keepers on the bidirectional lines only
  ppf_keeper #(
    .W(8)
  ) u_keeper (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .pin_in_i(bidir_in_i),
    .drive_oe_i(bidir_reg.oe),
    .keep_val_o(keep_val_o),
    .keep_en_o(keep_en_o)
  );

endmodule : ppf_port_ctrl

`default_nettype wire

// file: verif/ppf_board_model.sv
`timescale 1ns/1ns
`default_nettype none

// Board side: pull-ups on the bidirectional lines, optional drivers
module ppf_board_model
  import ppf_pkg::*;
(
  input wire ppf_bidir_drv_s bd_i,
  input wire ppf_fixed_drv_s fd_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  input wire logic [1:0] ext_fix_i,
  output logic [7:0] bidir_o,
  output logic [1:0] fix_io_o
);
  // A released line shows the board driver or else the pull-up
  assign bidir_o = (bd_i.oe & bd_i.out) |
    (~bd_i.oe & ((ext_en_i & ext_val_i) | ~ext_en_i));
  assign fix_io_o = (fd_i.oe[1:0] & fd_i.out[1:0]) |
    (~fd_i.oe[1:0] & ext_fix_i);
endmodule : ppf_board_model

`default_nettype wire

// file: verif/ppf_port_ctrl_sva.sv
`timescale 1ns/1ns
`default_nettype none

module ppf_port_ctrl_sva
  import ppf_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] bidir_in_i,
  input wire ppf_bidir_drv_s bidir_drv_o,
  input wire logic [7:0] keep_en_o,
  input wire logic [7:0] keep_val_o,
  input wire logic [2:0] fixed_in_i,
  input wire logic [1:0] fixed_io_in_i,
  input wire ppf_fixed_drv_s fixed_drv_o,
  input wire logic [1:0] comp_result_i,
  input wire logic comp_analog_o,
  input wire logic spi_en_i,
  input wire logic spi_slave_i,
  input wire logic spi_sck_out_i,
  input wire logic spi_sck_oe_i,
  input wire logic spi_din_o,
  input wire logic spi_sck_in_o,
  input wire logic spi_ss_o,
  input wire logic timer_ext_in_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_KEEP: assert property (keep_en_o == ~bidir_drv_o.oe)
    else $error("keeper not on undriven line");
  AST_KEEP_VAL: assert property ($past(nrst_i) |->
    keep_val_o == $past(bidir_in_i)) else $error("keeper level stale");
  AST_SCK_IN: assert property (spi_en_i |=>
    spi_sck_in_o == $past(fixed_io_in_i[0])) else $error("sck in wrong");
  AST_SPI_DIN: assert property (spi_en_i |=>
    spi_din_o == $past(bidir_in_i[0])) else $error("serial in wrong");
  AST_SPI_IN0: assert property (spi_en_i |=>
    !bidir_drv_o.oe[0]) else $error("line 0 driven in serial use");
  AST_SCK: assert property (spi_en_i |=>
    fixed_drv_o.oe[0] == $past(spi_sck_oe_i) &&
    fixed_drv_o.out[0] == $past(spi_sck_out_i)) else $error("sck wrong");
  AST_SS: assert property (spi_en_i && spi_slave_i |=>
    spi_ss_o == $past(fixed_io_in_i[1]) && !fixed_drv_o.oe[1])
    else $error("slave select wrong");
  AST_SS_OFF: assert property (!(spi_en_i && spi_slave_i) |=>
    spi_ss_o) else $error("slave select not idle");
  AST_FIX_OE: assert property ($past(nrst_i) && !$past(spi_en_i) |->
    fixed_drv_o.oe == 3'h7) else $error("fixed output not driven");
  AST_TIN_DIG: assert property (!comp_analog_o |=>
    timer_ext_in_o == $past(fixed_in_i[0])) else $error("timer in wrong");
  AST_TIN_ANA: assert property (comp_analog_o |=>
    timer_ext_in_o == $past(comp_result_i[0])) else $error("timer in bad");
endmodule : ppf_port_ctrl_sva

bind ppf_port_ctrl ppf_port_ctrl_sva chk_u (.ref_clk_i, .nrst_i,
  .bidir_in_i, .bidir_drv_o, .keep_en_o, .keep_val_o, .fixed_in_i,
  .fixed_io_in_i, .fixed_drv_o, .comp_result_i, .comp_analog_o, .spi_en_i,
  .spi_slave_i, .spi_sck_out_i, .spi_sck_oe_i, .spi_din_o, .spi_sck_in_o,
  .spi_ss_o, .timer_ext_in_o);

`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
  import ppf_pkg::*;
  logic ref_clk_i, nrst_i, ana, eo, eb, ef, sen, ssl, sdo, sko, skoe;
  logic sdi, sss, tout, irq;
  ppf_bus_req_s req;
  ppf_bidir_drv_s bd;
  ppf_fixed_drv_s fd;
  logic [7:0] rdata, bin, ken, xe, xv, v;
  logic [2:0] fin;
  logic [1:0] fio, cmp, xf;
  int err_total, checks;

  ppf_port_ctrl dut_u (.ref_clk_i, .nrst_i, .bus_req_i(req),
    .bus_rdata_o(rdata), .bidir_in_i(bin), .bidir_drv_o(bd), .keep_val_o(),
    .keep_en_o(ken), .fixed_in_i(fin), .fixed_io_in_i(fio),
    .fixed_drv_o(fd), .comp_result_i(cmp), .comp_analog_o(ana),
    .osc_low_emi_o(eo), .bidir_low_emi_o(eb), .fixed_low_emi_o(ef),
    .spi_en_i(sen), .spi_slave_i(ssl), .spi_dout_i(sdo),
    .spi_sck_out_i(sko), .spi_sck_oe_i(skoe), .spi_din_o(sdi),
    .spi_sck_in_o(), .spi_ss_o(sss), .timer_out_i(tout),
    .timer_ext_in_o(), .irq_o(irq));
  ppf_board_model brd_u (.bd_i(bd), .fd_i(fd), .ext_en_i(xe),
    .ext_val_i(xv), .ext_fix_i(xf), .bidir_o(bin), .fix_io_o(fio));

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i) req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i) req <= '0;
    #1 d = rdata;
  endtask : rd
  task automatic nx;
    @(posedge ref_clk_i);
    #1;
  endtask : nx
  task automatic tend(input string s);
    $display("%s done", s);
  endtask : tend
  task automatic test_done;
    $display("checks=%0d errors=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #100000;
    err_total++;
    test_done();
  end

  initial begin
    {nrst_i, ssl, sen, sdo, sko, skoe, tout} = '0;
    {req, fin, cmp, xe, xv, xf, err_total, checks} = '0;
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(ADDR_BIDIR_DIR, v); `CHK(v, BIDIR_DIR_RST)
    `CHK({bd.oe, fd.oe}, 11'h007)
    rd(4'h9, v); `CHK(v, 8'h00)
    tend("reset");
    wr(ADDR_BIDIR_DIR, 8'h5a);
    wr(ADDR_BIDIR_DATA, 8'h3c);
    nx;
    `CHK({bd.oe, bd.out & bd.oe}, 16'ha524)
    `CHK(ken, 8'h5a)
    wr(ADDR_PORT_MODE, 8'h01);
    nx;
    `CHK({bd.oe, bd.out & bd.oe}, 16'h8100)
    rd(ADDR_BIDIR_DATA, v); `CHK(v, 8'h7e)
    tend("bidir");
    wr(ADDR_PORT_MODE, 8'h00);
    wr(ADDR_BIDIR_DIR, 8'h80);
    @(posedge ref_clk_i) {sen, ssl, sdo, sko, skoe, xf, xe, xv} <= 23'h7c0101;
    nx;
    nx;
    `CHK({bd.oe[0], bd.oe[7], bd.out[7], sdi}, 4'h7)
    `CHK({fd.oe[1:0], fd.out[0], sss}, 4'h6)
    @(posedge ref_clk_i) ssl <= 1'b0;
    nx;
    `CHK({fd.oe[1], sss}, 2'b11)
    @(posedge ref_clk_i) {sen, fin} <= 4'h5;
    nx;
    `CHK(sss, 1'b1)
    tend("serial");
    wr(ADDR_FIXED_DATA, 8'h70);
    nx;
    `CHK({fd.out, fd.oe}, 6'h3f)
    rd(ADDR_FIXED_DATA, v); `CHK(v, 8'h7a)
    @(posedge ref_clk_i) cmp <= 2'b10;
    wr(ADDR_PORT_CTRL, 8'h01);
    wr(ADDR_PORT_MODE, 8'h04);
    nx;
    `CHK(fd.out, 3'b010)
    @(posedge ref_clk_i) tout <= 1'b1;
    nx;
    `CHK(fd.out[2], 1'b1)
    // Each low-emission bit in the control register drives only its own output
    for (int i = 1; i < 4; i++) begin
      wr(ADDR_PORT_CTRL, 8'h01 << i);
      nx;
      `CHK({eo, ef, eb}, 3'(1 << (i - 1)))
    end
    tend("fixed");
    @(posedge ref_clk_i) fin <= 3'h4;
    wr(ADDR_IRQ_MASK, 8'h07);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_IRQ_EDGE, {c[1:0], 6'h00});
      wr(ADDR_IRQ_STAT, 8'h07);
      @(posedge ref_clk_i) fin[1:0] <= 2'b11;
      rd(ADDR_IRQ_STAT, v); `CHK(v, (c == 0) ? 8'h00 : 8'h05)
      `CHK(irq, (c != 0))
      wr(ADDR_IRQ_STAT, 8'h07);
      @(posedge ref_clk_i) fin[1:0] <= 2'b00;
      rd(ADDR_IRQ_STAT, v); `CHK(v, (c == 1) ? 8'h00 : 8'h05)
    end
    wr(ADDR_IRQ_MASK, 8'h00);
    nx;
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_STAT, 8'h07);
    @(posedge ref_clk_i) fin[2] <= 1'b0;
    rd(ADDR_IRQ_STAT, v); `CHK(v, 8'h02)
    wr(ADDR_IRQ_STAT, 8'h07);
    @(posedge ref_clk_i) fin[2] <= 1'b1;
    rd(ADDR_IRQ_STAT, v); `CHK(v, 8'h00)
    rd(ADDR_FIXED_DATA, v); `CHK(v[3:1], 3'b100)
    wr(ADDR_PORT_MODE, 8'h02);
    nx;
    `CHK(ana, 1'b1)
    wr(ADDR_IRQ_STAT, 8'h07);
    @(posedge ref_clk_i) {fin[2], cmp} <= 3'b001;
    rd(ADDR_IRQ_STAT, v); `CHK(v, 8'h05)
    rd(ADDR_FIXED_DATA, v); `CHK(v[3:1], 3'b001)
    tend("irq");
    test_done();
  end
endmodule : tb_top

`default_nettype wire
